/* File: logic/cpd_clock_divider.sv */
// cpu-to-peripheral clock ratio and fast rc postscaler control with wishbone registers
// Functional notes
// R01: with recovery set, an interrupt clears enable and forces ratio back to 1:1.
// R02: with recovery clear, interrupts leave enable and ratio untouched.
// R03: ratio field bits 14:12 selects 1:1 to 1:128, doubling per code.
// R04: with enable bit 11 set, peripheral clock follows the selected ratio.
// R05: with enable clear, cpu and peripheral run 1:1 regardless of field.
// R06: postscaler field bits 10:8 divides fast rc only for source 111 or 001.
// R07: unimplemented bits read back as zero.
// R08: postscaler divisor is two to the power of the field value; the code divides by 256, not 128, for field value 7.
//
// Register access over Wishbone and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "cpd_defs.svh"
module cpd_clock_divider (
	// clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] sel_i,
	input wire logic [`CPD_ADDR_W-1:0] adr_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// system events
	input wire logic irq_i,
	input wire logic [2:0] current_source_code_i,
	input wire logic fast_internal_rc_tick_i,
	// clock enables and postscaler active level out
	output logic periph_en_o,
	output logic post_en_o,
	output logic post_active_o
);
	cpd_pkg::cpd_state_t s_q;
	cpd_pkg::cpd_state_t s_d;
	// control byte after reset, cut to the field width on purpose
	localparam cpd_pkg::cpd_ctrl_t ctrl_rst = cpd_pkg::cpd_ctrl_t'(8'(`CPD_CTRL_RESET >> `CPD_POST_LO));

	// divide count limit: 2^code - 1
	function automatic logic [7:0] cpd_limit(input logic [2:0] code);
		cpd_limit = 8'((9'h001 << code) - 9'h001);
	endfunction

	// control word as seen on the bus, unimplemented bits zero
	function automatic logic [15:0] cpd_pack(input cpd_pkg::cpd_ctrl_t c);
		logic [15:0] w;
		w = 16'h0000;
		w[`CPD_BIT_RECOVER] = c.recover;
		w[`CPD_RATIO_HI:`CPD_RATIO_LO] = c.ratio;
		w[`CPD_BIT_ENABLE] = c.enable;
		w[`CPD_POST_HI:`CPD_POST_LO] = c.post;
		cpd_pack = w & `CPD_CTRL_MASK; // R07
	endfunction

	logic wb_req;
	logic wr_ctrl;
	logic [15:0] wmerge;
	logic [7:0] ratio_lim;
	logic [7:0] post_lim;
	logic src_frc;
	assign wb_req = cyc_i && stb_i && !s_q.ack;
	assign wr_ctrl = wb_req && we_i && adr_i == `CPD_OFS_CTRL;
	assign src_frc = current_source_code_i == `CPD_SRC_FRC_A
		|| current_source_code_i == `CPD_SRC_FRC_B; // R06
	assign ratio_lim = s_q.ctrl.enable ? cpd_limit(s_q.ctrl.ratio) : `CPD_CNT_ZERO; // R05
	// top code skips 128 and divides by 256
	assign post_lim = s_q.ctrl.post == `CPD_POST_TOP ? `CPD_POST_TOP_LIM // R06
		: cpd_limit(s_q.ctrl.post); // R08

	// byte-lane merge of a control write
	always_comb begin
		wmerge = cpd_pack(s_q.ctrl);
		if (sel_i[0]) begin
			wmerge[7:0] = dat_i[7:0];
		end
		if (sel_i[1]) begin
			wmerge[15:8] = dat_i[15:8];
		end
	end

	// next state
	always_comb begin
		s_d = s_q;
		s_d.ack = wb_req;
		// register write
		if (wr_ctrl) begin
			s_d.ctrl.recover = wmerge[`CPD_BIT_RECOVER];
			s_d.ctrl.ratio = wmerge[`CPD_RATIO_HI:`CPD_RATIO_LO]; // R03
			s_d.ctrl.enable = wmerge[`CPD_BIT_ENABLE];
			s_d.ctrl.post = wmerge[`CPD_POST_HI:`CPD_POST_LO];
		end
		// interrupt recovery wins over a simultaneous write
		if (irq_i && s_q.ctrl.recover) begin // R01 R02
			s_d.ctrl.enable = 1'b0;
			s_d.ctrl.ratio = 3'h0;
		end
		// read data
		s_d.rdata = 32'h0000_0000;
		if (wb_req && !we_i) begin
			if (adr_i == `CPD_OFS_CTRL) begin
				s_d.rdata = {16'h0000, cpd_pack(s_q.ctrl)}; // R07
			end else if (adr_i == `CPD_OFS_STAT) begin
				s_d.rdata = {29'h0, s_q.post_active, s_q.post_en, s_q.periph_en};
			end
		end
		// peripheral enable every ratio_lim+1 cpu cycles
		if (s_q.periph_cnt >= ratio_lim) begin // R04 R05
			s_d.periph_cnt = `CPD_CNT_ZERO;
			s_d.periph_en = 1'b1;
		end else begin
			s_d.periph_cnt = s_q.periph_cnt + `CPD_ONE;
			s_d.periph_en = 1'b0;
		end
		// fast rc postscaler, only for fast rc sources
		s_d.post_active = src_frc;
		s_d.post_en = 1'b0;
		if (!src_frc) begin
			s_d.post_cnt = `CPD_CNT_ZERO;
		end else if (fast_internal_rc_tick_i) begin // R06
			if (s_q.post_cnt >= post_lim) begin
				s_d.post_cnt = `CPD_CNT_ZERO;
				s_d.post_en = 1'b1;
			end else begin
				s_d.post_cnt = s_q.post_cnt + `CPD_ONE;
			end
		end
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '0;
			s_q.ctrl <= ctrl_rst;
		end else if (ce_i) begin
			s_q <= s_d;
		end
	end

	assign dat_o = s_q.rdata;
	assign ack_o = s_q.ack;
	assign periph_en_o = s_q.periph_en;
	assign post_en_o = s_q.post_en;
	assign post_active_o = s_q.post_active;

	// interrupt with recovery returns to 1:1
	AST_RECOVER: assert property (@(posedge clk_i) disable iff (rst_i) // R01
		ce_i && irq_i && s_q.ctrl.recover |=> !s_q.ctrl.enable && s_q.ctrl.ratio == 3'h0)
		else $error("recovery did not clear ratio");
	// no recovery: interrupt keeps settings
	AST_NO_RECOVER: assert property (@(posedge clk_i) disable iff (rst_i) // R02
		ce_i && irq_i && !s_q.ctrl.recover && !wr_ctrl |=> $stable(s_q.ctrl))
		else $error("interrupt changed settings");
	// ratio 1:2 gives alternating enables
	AST_RATIO2: assert property (@(posedge clk_i) disable iff (rst_i) // R03 R04
		ce_i && s_q.ctrl.enable && s_q.ctrl.ratio == 3'h1 && periph_en_o && !irq_i
		&& !wr_ctrl ##1 ce_i |-> !periph_en_o)
		else $error("ratio 1:2 wrong");
	// disabled: peripheral enable every cycle
	AST_UNITY: assert property (@(posedge clk_i) disable iff (rst_i) // R05
		ce_i && !s_q.ctrl.enable |=> periph_en_o)
		else $error("1:1 not kept");
	// postscaler silent for other sources
	AST_POST_SRC: assert property (@(posedge clk_i) disable iff (rst_i) // R06
		ce_i && !src_frc |=> !post_en_o)
		else $error("postscaler ran off fast rc");
	// unimplemented bits zero
	AST_RSVD: assert property (@(posedge clk_i) disable iff (rst_i) // R07
		ack_o |-> dat_o[31:16] == 16'h0000 && dat_o[7:3] == 5'h00)
		else $error("reserved bits nonzero");
	// divide by one passes every tick
	AST_POST1: assert property (@(posedge clk_i) disable iff (rst_i) // R08
		ce_i && src_frc && fast_internal_rc_tick_i && s_q.ctrl.post == 3'h0
		&& s_q.post_cnt == 8'h00 |=> post_en_o)
		else $error("divide by one missed");
	// ack one cycle only
	AST_ACK: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && ack_o |=> !ack_o)
		else $error("ack held");
	// reset loads the control byte
	AST_RESET_CTRL: assert property (@(posedge clk_i)
		rst_i |=> s_q.ctrl == ctrl_rst)
		else $error("reset control value wrong");
	// reset clears ack
	AST_RESET_ACK: assert property (@(posedge clk_i)
		rst_i |=> !ack_o)
		else $error("ack after reset");
	// reset clears enables
	AST_RESET_OUT: assert property (@(posedge clk_i)
		rst_i |=> !periph_en_o && !post_en_o && !post_active_o)
		else $error("enables after reset");
	// low clock enable freezes everything
	AST_FREEZE: assert property (@(posedge clk_i) disable iff (rst_i)
		!ce_i |=> $stable(s_q))
		else $error("state moved while frozen");
	// bus checks
	// request answered next cycle
	AST_ACK_ANSWER: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("request not acked");
	// no ack without request
	AST_ACK_CAUSE: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && !(cyc_i && stb_i) |=> !ack_o)
		else $error("ack without request");
	// upper lane write lands in control
	AST_WRITE_LANDS: assert property (@(posedge clk_i) disable iff (rst_i) // R03
		ce_i && wr_ctrl && sel_i[1] && !irq_i
		|=> {16'h0000, s_q.ctrl, 8'h00} == ($past(dat_i) & 32'h0000_ff00))
		else $error("write did not land");
	// control holds without write or interrupt
	AST_NO_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && !wr_ctrl && !irq_i |=> $stable(s_q.ctrl))
		else $error("control changed unasked");
	// lane 0 only touches no field
	AST_LANE0: assert property (@(posedge clk_i) disable iff (rst_i) // R07
		ce_i && wr_ctrl && !sel_i[1] && !irq_i |=> $stable(s_q.ctrl))
		else $error("low lane changed control");
	// recovery bit only moves by software
	AST_RECOVER_SW: assert property (@(posedge clk_i) disable iff (rst_i) // R01
		ce_i && !wr_ctrl |=> $stable(s_q.ctrl.recover))
		else $error("recovery bit moved");
	// postscaler field only moves by software
	AST_POST_SW: assert property (@(posedge clk_i) disable iff (rst_i) // R06
		ce_i && !wr_ctrl |=> $stable(s_q.ctrl.post))
		else $error("postscaler field moved");
	// control read returns packed fields
	AST_READ_CTRL: assert property (@(posedge clk_i) disable iff (rst_i) // R07
		ce_i && wb_req && !we_i && adr_i == `CPD_OFS_CTRL && !irq_i
		|=> dat_o == {16'h0000, s_q.ctrl, 8'h00})
		else $error("control read wrong");
	// status read upper bits zero
	AST_READ_STAT: assert property (@(posedge clk_i) disable iff (rst_i) // R07
		ce_i && wb_req && !we_i && adr_i == `CPD_OFS_STAT |=> dat_o[31:3] == 29'h0)
		else $error("status upper bits set");
	// status shows the postscaler source level
	AST_STAT_ACTIVE: assert property (@(posedge clk_i) disable iff (rst_i) // R06
		ce_i && wb_req && !we_i && adr_i == `CPD_OFS_STAT |=> dat_o[2] == $past(post_active_o))
		else $error("status active bit wrong");
	// unmapped read returns zero
	AST_READ_HOLE: assert property (@(posedge clk_i) disable iff (rst_i) // R07
		ce_i && wb_req && !we_i && adr_i != `CPD_OFS_CTRL && adr_i != `CPD_OFS_STAT
		|=> dat_o == 32'h0000_0000)
		else $error("hole read nonzero");
	// no read, no data
	AST_IDLE_DATA: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && !wb_req |=> dat_o == 32'h0000_0000)
		else $error("data without read");
	// write cycles return zero data
	AST_WRITE_DATA: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && wb_req && we_i |=> dat_o == 32'h0000_0000)
		else $error("data on write");
	// clock ratio checks
	// recovery leaves recover and postscaler alone
	AST_RECOVER_KEEP: assert property (@(posedge clk_i) disable iff (rst_i) // R01
		ce_i && irq_i && s_q.ctrl.recover && !wr_ctrl
		|=> $stable(s_q.ctrl.post) && s_q.ctrl.recover)
		else $error("recovery touched other fields");
	// enable pulse only at counter zero
	AST_PERIPH_AT_ZERO: assert property (@(posedge clk_i) disable iff (rst_i) // R04
		periph_en_o |-> s_q.periph_cnt == 8'h00)
		else $error("enable off zero");
	// reduced ratio never pulses twice in a row
	AST_RATIO_GAP: assert property (@(posedge clk_i) disable iff (rst_i) // R03 R04
		ce_i && periph_en_o && s_q.ctrl.enable && s_q.ctrl.ratio != 3'h0 |=> !periph_en_o)
		else $error("reduced ratio pulsed twice");
	// below the limit no pulse
	AST_RATIO_PULSE: assert property (@(posedge clk_i) disable iff (rst_i) // R04
		ce_i && s_q.periph_cnt < ratio_lim |=> !periph_en_o)
		else $error("early peripheral pulse");
	// at the limit a pulse
	AST_RATIO_FIRE: assert property (@(posedge clk_i) disable iff (rst_i) // R04 R05
		ce_i && s_q.periph_cnt >= ratio_lim |=> periph_en_o)
		else $error("peripheral pulse missed");
	// postscaler checks
	// active level follows the source code
	AST_ACTIVE_LEVEL: assert property (@(posedge clk_i) disable iff (rst_i) // R06
		ce_i |=> post_active_o == $past(src_frc))
		else $error("active level wrong");
	// no tick, no postscaled pulse
	AST_POST_NO_TICK: assert property (@(posedge clk_i) disable iff (rst_i) // R06
		ce_i && !fast_internal_rc_tick_i |=> !post_en_o)
		else $error("pulse without tick");
	// postscaled pulse only at counter zero
	AST_POST_AT_ZERO: assert property (@(posedge clk_i) disable iff (rst_i) // R06
		post_en_o |-> s_q.post_cnt == 8'h00)
		else $error("postscaled pulse off zero");
	// counter parked while not on fast rc
	AST_POST_OFF_CNT: assert property (@(posedge clk_i) disable iff (rst_i) // R06
		!post_active_o |-> s_q.post_cnt == 8'h00)
		else $error("postscaler counted off source");
	// top code divides by 256, not 128
	AST_POST256: assert property (@(posedge clk_i) disable iff (rst_i) // R06
		ce_i && src_frc && fast_internal_rc_tick_i && s_q.ctrl.post == 3'h7
		&& s_q.post_cnt == 8'h7f |=> !post_en_o)
		else $error("top code divided by 128");
	// tick at the limit pulses
	AST_POST_FIRE: assert property (@(posedge clk_i) disable iff (rst_i) // R08
		ce_i && src_frc && fast_internal_rc_tick_i && s_q.post_cnt >= post_lim |=> post_en_o)
		else $error("postscaled pulse missed");
	// tick below the limit stays quiet
	AST_POST_HOLD: assert property (@(posedge clk_i) disable iff (rst_i) // R08
		ce_i && src_frc && fast_internal_rc_tick_i && s_q.post_cnt < post_lim |=> !post_en_o)
		else $error("early postscaled pulse");
	// counter waits for ticks
	AST_POST_STILL: assert property (@(posedge clk_i) disable iff (rst_i) // R06
		ce_i && src_frc && !fast_internal_rc_tick_i |=> $stable(s_q.post_cnt))
		else $error("postscaler counted without tick");
endmodule
`default_nettype wire

/* File: logic/cpd_defs.svh */
// register offsets, field positions, reset values and widths of the clock divider
`ifndef CPD_DEFS_SVH
`define CPD_DEFS_SVH
`define CPD_ADDR_W 4
`define CPD_OFS_CTRL 4'h0
`define CPD_OFS_STAT 4'h4
`define CPD_BIT_RECOVER 15
`define CPD_RATIO_HI 14
`define CPD_RATIO_LO 12
`define CPD_BIT_ENABLE 11
`define CPD_POST_HI 10
`define CPD_POST_LO 8
`define CPD_CTRL_MASK 16'hff00
`define CPD_CTRL_RESET 16'h3100
`define CPD_SRC_FRC_A 3'h7
`define CPD_SRC_FRC_B 3'h1
`define CPD_POST_TOP 3'h7
`define CPD_POST_TOP_LIM 8'hff
`define CPD_CNT_W 8
`define CPD_CNT_ZERO 8'h00
`define CPD_ONE 8'h01
`endif

/* File: logic/cpd_pkg.sv */
// types of the cpu / peripheral clock divider
`default_nettype none
package cpd_pkg;
	typedef struct packed {
		logic recover;
		logic [2:0] ratio;
		logic enable;
		logic [2:0] post;
	} cpd_ctrl_t;
	typedef struct packed {
		cpd_ctrl_t ctrl;
		logic [7:0] periph_cnt;
		logic [7:0] post_cnt;
		logic periph_en;
		logic post_en;
		logic post_active;
		logic ack;
		logic [31:0] rdata;
	} cpd_state_t;
endpackage
`default_nettype wire

/* File: testbench/cpd_clock_divider_tb.sv */
// self-checking bench for the clock divider
`timescale 1ns/1ns
`default_nettype none
module cpd_clock_divider_tb;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, irq = 0, tick = 0, ce = 1;
	logic [3:0] adr = 4'h0;
	logic [2:0] src = 3'h0;
	logic [31:0] wd = 32'h0, dat, rd;
	logic ack, pe, po, pa;
	int n_fail = 0, samples_checked = 0, n, k;
	cpd_clock_divider cpd_clock_divider_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
		.cyc_i(cyc), .stb_i(stb), .we_i(we), .sel_i(4'h3), .adr_i(adr), .dat_i(wd),
		.dat_o(dat), .ack_o(ack), .irq_i(irq), .current_source_code_i(src),
		.fast_internal_rc_tick_i(tick), .periph_en_o(pe), .post_en_o(po),
		.post_active_o(pa));
	// 50 mhz clock
	initial forever #10 clk_i = ~clk_i;
	// one wishbone cycle, held until ack
	task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int i;
		i = 0;
		@(posedge clk_i);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wd <= d;
		do begin
			@(negedge clk_i);
			i++;
		end while (ack !== 1'b1 && i < 50);
		rd = dat;
		@(posedge clk_i);
		cyc <= 0;
		stb <= 0;
		we <= 0;
		if (i >= 50) n_fail++;
	endtask
	// compare seen against expected
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask
	// settle, then count enable pulses over len cycles, 128 by default
	task cnt(input bit p, input int len = 128);
		repeat (130) @(posedge clk_i);
		n = 0;
		repeat (len) begin
			@(negedge clk_i);
			if ((p ? po : pe) === 1'b1) n++;
		end
	endtask
	// one interrupt pulse
	task pulse;
		@(posedge clk_i) irq <= 1;
		@(posedge clk_i) irq <= 0;
	endtask
	task end_of_test;
		$display("fails %0d checks %0d", n_fail, samples_checked);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// watchdog
	initial begin
		#1000000;
		n_fail++;
		end_of_test;
	end
	// test sequence
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 0;
		wb(0, 4'h0, 0);
		chk("ctrl", rd, 32'h3100);
		wb(1, 4'h0, 32'hffffffff);
		wb(0, 4'h0, 0);
		chk("ctrl", rd, 32'hff00);
		wb(0, 4'h8, 0);
		chk("hole", rd, 0);
		wb(1, 4'h0, 32'h7000);
		cnt(0);
		chk("ratio", n, 128);
		for (k = 0; k < 8; k++) begin
			wb(1, 4'h0, {16'h0, 1'b0, k[2:0], 1'b1, 11'h0});
			cnt(0);
			chk("ratio", n, 128 >> k);
		end
		wb(1, 4'h0, 32'h3900);
		pulse;
		wb(0, 4'h0, 0);
		chk("ctrl", rd, 32'h3900);
		wb(1, 4'h0, 32'hb900);
		pulse;
		wb(0, 4'h0, 0);
		chk("ctrl", rd, 32'h8100);
		cnt(0);
		chk("ratio", n, 128);
		src <= 3'h7;
		tick <= 1;
		wb(1, 4'h0, 32'h0200);
		cnt(1);
		chk("post", n, 32);
		chk("act", pa, 1);
		wb(0, 4'h4, 0);
		chk("stat", rd & 32'h5, 32'h5);
		wb(1, 4'h0, 32'h0700);
		cnt(1, 512);
		chk("post", n, 2);
		src <= 3'h2;
		cnt(1);
		chk("post", n, 0);
		chk("act", pa, 0);
		@(posedge clk_i) ce <= 0;
		repeat (4) @(posedge clk_i);
		ce <= 1;
		end_of_test;
	end
endmodule
`default_nettype wire
